/* rtl/scsg_pkg_pin.sv */
// constants for the strap/configuration pin block and the per-pin output cell
`timescale 1ns/1ps
`default_nettype none

package scsg_pkg;
  // ----------------------------------------------------------------
  // pin and strap layout
  // ----------------------------------------------------------------
  localparam int unsigned PIN_COUNT = 5;
  localparam int unsigned CODE_LSB = 0;
  localparam int unsigned CODE_W = 3;
  localparam int unsigned ZERO_LSB = 3;
  localparam int unsigned ZERO_W = 2;
  localparam int unsigned CFG_COUNT = 7;
  localparam int unsigned STATUS_W = 8;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned MODE_W = 2;
  localparam logic [2:0] CODE_FACTORY = 3'h7;
  localparam logic [1:0] ZERO_REQUIRED = 2'h0;
  localparam logic [2:0] INDEX_RESET = 3'h0;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_MHZ = 200;
  localparam int unsigned READY_DELAY_MS = 500;
  localparam int unsigned RESET_HOLD_MS = 2;
  localparam int unsigned READY_CYCLES = READY_DELAY_MS * CLOCK_MHZ * 1000;
  localparam int unsigned READY_CNT_W = 32;

  typedef enum logic [1:0] {
    SCSG_MODE_INPUT = 2'b00,
    SCSG_MODE_OUTPUT = 2'b01,
    SCSG_MODE_STATUS = 2'b10,
    SCSG_MODE_IRQ = 2'b11
  } scsg_mode_t;

  typedef enum logic [1:0] {
    SCSG_ST_SAMPLE = 2'b00,
    SCSG_ST_LOAD = 2'b01,
    SCSG_ST_WAIT = 2'b10,
    SCSG_ST_RUN = 2'b11
  } scsg_state_t;
endpackage

module scsg_pin (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_active,
  input wire logic [1:0] i_mode,
  input wire logic i_gpo_value,
  input wire logic i_status_bit,
  input wire logic i_irq,
  input wire logic i_pulldown_dis,
  output logic o_out,
  output logic o_oe,
  output logic o_pulldown_en
);
  scsg_pkg::scsg_mode_t mode;
  assign mode = scsg_pkg::scsg_mode_t'(i_mode);

  // ----------------------------------------------------------------
  // output driver
  // ----------------------------------------------------------------
  // the pin stays released until the straps are latched, so a strap resistor is never fought
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_out <= 1'b0;
      o_oe <= 1'b0;
    end else if (i_clk_en) begin
      o_oe <= i_active && (mode != scsg_pkg::SCSG_MODE_INPUT);
      case (mode)
        scsg_pkg::SCSG_MODE_OUTPUT: o_out <= i_gpo_value;
        scsg_pkg::SCSG_MODE_STATUS: o_out <= i_status_bit;
        scsg_pkg::SCSG_MODE_IRQ: o_out <= i_irq;
        default: o_out <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pull-down
  // ----------------------------------------------------------------
  // the disable only takes effect once straps are taken; the pull-down defines them before
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_pulldown_en <= 1'b1;
    end else if (i_clk_en) begin
      o_pulldown_en <= !(i_active && i_pulldown_dis);
    end
  end

  pulldown_ctl_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_clk_en && i_active && i_pulldown_dis |=> !o_pulldown_en)
    else $error("pull-down not disabled by its field");
  status_drive_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_clk_en && i_active && mode == scsg_pkg::SCSG_MODE_STATUS |=> o_oe && o_out == $past(i_status_bit))
    else $error("status pin does not follow its status bit");
endmodule

`default_nettype wire

/* rtl/scsg_top.sv */
// strap sampling, configuration select and multi-purpose pin control
// How it works
// - After start-up each pin can drive a software value or a chosen internal status bit.
// - A pin in interrupt mode goes high when the device status changes until software acknowledges the read.
// - Every pin has a pull-down that its own control bit can switch off.
// - At reset release pins two..zero are latched; codes 0 to 6 load that configuration, 7 picks factory default.
// - If the selected configuration is empty the device comes up in factory default instead.
// - Registers are usable after the fixed delay or once the ready flag rises; the board waits for either.
`timescale 1ns/1ps
`default_nettype none

module scsg_top #(
  parameter int unsigned P_READY_CYCLES = scsg_pkg::READY_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic [4:0] i_pin_in,
  output logic [4:0] o_pin_out,
  output logic [4:0] o_pin_oe,
  output logic [4:0] o_pulldown_en,
  input wire logic [9:0] i_pin_mode,
  input wire logic [4:0] i_gpo_value,
  input wire logic [4:0] i_pulldown_dis,
  input wire logic [14:0] i_status_sel,
  input wire logic [7:0] i_status,
  input wire logic i_irq_ack,
  input wire logic [6:0] i_cfg_present,
  output logic o_cfg_load,
  output logic [2:0] o_cfg_index,
  output logic o_factory_default,
  output logic o_strap_fault,
  output logic o_regs_ready,
  output logic o_irq_pending
);
  scsg_pkg::scsg_state_t state_reg;
  logic [2:0] code_reg;
  logic [1:0] zero_reg;
  logic [31:0] ready_cnt_reg;
  logic [7:0] status_prev_reg;
  logic active;
  logic status_change;
  logic cfg_empty;
  logic [7:0] cfg_present_ext;

  assign active = (state_reg != scsg_pkg::SCSG_ST_SAMPLE);
  // code seven has no stored image; its slot reads as present so the lookup never leaves the vector
  assign cfg_present_ext = {1'b1, i_cfg_present};
  assign status_change = active && (i_status != status_prev_reg);
  assign cfg_empty = (code_reg != scsg_pkg::CODE_FACTORY) && !cfg_present_ext[code_reg];

  // ----------------------------------------------------------------
  // start-up sequence
  // ----------------------------------------------------------------
  // straps are taken on the first enabled edge after release, never from the reset branch
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= scsg_pkg::SCSG_ST_SAMPLE;
      code_reg <= scsg_pkg::INDEX_RESET;
      zero_reg <= scsg_pkg::ZERO_REQUIRED;
    end else if (i_clk_en) begin
      case (state_reg)
        scsg_pkg::SCSG_ST_SAMPLE: begin
          code_reg <= i_pin_in[scsg_pkg::CODE_LSB +: scsg_pkg::CODE_W];
          zero_reg <= i_pin_in[scsg_pkg::ZERO_LSB +: scsg_pkg::ZERO_W];
          state_reg <= scsg_pkg::SCSG_ST_LOAD;
        end
        scsg_pkg::SCSG_ST_LOAD: state_reg <= scsg_pkg::SCSG_ST_WAIT;
        scsg_pkg::SCSG_ST_WAIT: begin
          if (ready_cnt_reg >= P_READY_CYCLES - 1) begin
            state_reg <= scsg_pkg::SCSG_ST_RUN;
          end
        end
        default: state_reg <= scsg_pkg::SCSG_ST_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // configuration select
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_cfg_load <= 1'b0;
      o_cfg_index <= scsg_pkg::INDEX_RESET;
      o_factory_default <= 1'b0;
      o_strap_fault <= 1'b0;
    end else if (i_clk_en) begin
      o_cfg_load <= 1'b0;
      if (state_reg == scsg_pkg::SCSG_ST_LOAD) begin
        // index follows the code for every stored image, 4 and 5 included
        o_cfg_index <= code_reg;
        if (code_reg == scsg_pkg::CODE_FACTORY || cfg_empty) begin
          o_factory_default <= 1'b1;
        end else begin
          o_cfg_load <= 1'b1;
        end
        o_strap_fault <= (zero_reg != scsg_pkg::ZERO_REQUIRED);
      end
    end
  end

  // ----------------------------------------------------------------
  // register access delay
  // ----------------------------------------------------------------
  // counting starts after the load so the ready flag never precedes the image
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ready_cnt_reg <= 32'h0;
      o_regs_ready <= 1'b0;
    end else if (i_clk_en) begin
      if (state_reg == scsg_pkg::SCSG_ST_WAIT) begin
        ready_cnt_reg <= ready_cnt_reg + 32'h1;
      end
      o_regs_ready <= (state_reg == scsg_pkg::SCSG_ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  // a change landing on the acknowledge cycle keeps the flag set
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      status_prev_reg <= 8'h00;
      o_irq_pending <= 1'b0;
    end else if (i_clk_en) begin
      status_prev_reg <= i_status;
      if (status_change) begin
        o_irq_pending <= 1'b1;
      end else if (i_irq_ack) begin
        o_irq_pending <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < scsg_pkg::PIN_COUNT; g++) begin : g_pin
      scsg_pin u_pin (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_active(active),
        .i_mode(i_pin_mode[g*scsg_pkg::MODE_W +: scsg_pkg::MODE_W]),
        .i_gpo_value(i_gpo_value[g]),
        .i_status_bit(i_status[i_status_sel[g*scsg_pkg::SEL_W +: scsg_pkg::SEL_W]]),
        .i_irq(o_irq_pending),
        .i_pulldown_dis(i_pulldown_dis[g]),
        .o_out(o_pin_out[g]),
        .o_oe(o_pin_oe[g]),
        .o_pulldown_en(o_pulldown_en[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  code_select_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_clk_en && state_reg == scsg_pkg::SCSG_ST_SAMPLE && i_pin_in[2:0] != 3'h7
      && cfg_present_ext[i_pin_in[2:0]] ##1 i_clk_en
    |=> o_cfg_load && o_cfg_index == $past(code_reg) && !o_factory_default)
    else $error("stored configuration not loaded for strap code");
  factory_code_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_clk_en && state_reg == scsg_pkg::SCSG_ST_LOAD && code_reg == 3'h7
    |=> o_factory_default && !o_cfg_load)
    else $error("code seven did not select factory default");
  empty_fallback_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_clk_en && state_reg == scsg_pkg::SCSG_ST_LOAD && cfg_empty
    |=> o_factory_default && !o_cfg_load)
    else $error("empty configuration not replaced by factory default");
  high_codes_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_clk_en && state_reg == scsg_pkg::SCSG_ST_LOAD && (code_reg == 3'h4 || code_reg == 3'h5)
    |=> o_cfg_index == $past(code_reg))
    else $error("codes four and five mapped wrongly");
  irq_raise_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_clk_en && status_change |=> o_irq_pending ##1 (!i_clk_en || o_irq_pending || $past(i_irq_ack)))
    else $error("status change lost");
  irq_pin_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_clk_en && active && i_pin_mode[1:0] == 2'b11 |=> o_pin_oe[0] && o_pin_out[0] == $past(o_irq_pending))
    else $error("interrupt pin does not follow pending flag");
  ready_delay_a: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(o_regs_ready) |-> ready_cnt_reg >= P_READY_CYCLES)
    else $error("registers ready before the access delay");
  strap_fault_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_clk_en && state_reg == scsg_pkg::SCSG_ST_LOAD |=> o_strap_fault == ($past(zero_reg) != 2'h0))
    else $error("strap fault flag wrong");
  load_pulse_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_clk_en && o_cfg_load |=> !o_cfg_load)
    else $error("configuration load pulse longer than one cycle");
  factory_sticky_a: assert property (@(posedge i_clock) disable iff (i_rst)
    o_factory_default |=> o_factory_default)
    else $error("factory default flag dropped before reset");
  pins_released_a: assert property (@(posedge i_clock) disable iff (i_rst)
    state_reg == scsg_pkg::SCSG_ST_SAMPLE |-> o_pin_oe == 5'h00 && o_pulldown_en == 5'h1F)
    else $error("pin driven or pull-down off before straps were taken");
  ready_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
    state_reg != scsg_pkg::SCSG_ST_RUN |=> !o_regs_ready)
    else $error("registers ready outside the run state");
  irq_set_wins_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_clk_en && status_change && i_irq_ack |=> o_irq_pending)
    else $error("acknowledge swallowed a simultaneous status change");
  irq_clear_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_clk_en && i_irq_ack && !status_change |=> !o_irq_pending)
    else $error("acknowledge did not clear the interrupt flag");
  freeze_state_a: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_clk_en |=> $stable(state_reg) && $stable(o_cfg_load) && $stable(o_cfg_index))
    else $error("start-up state moved while clock enable was low");
  freeze_irq_a: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_clk_en |=> $stable(o_irq_pending) && $stable(o_pin_out))
    else $error("interrupt or pin moved while clock enable was low");
  freeze_count_a: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_clk_en |=> $stable(ready_cnt_reg) && $stable(o_regs_ready))
    else $error("access delay counted while clock enable was low");
endmodule

`default_nettype wire

/* bench/scsg_board.sv */
// board-side model: strap levels around reset release, then controller outputs
`timescale 1ns/1ps
`default_nettype none

module scsg_board (
  input wire logic i_clock,
  input wire logic i_released,
  input wire logic [2:0] i_code,
  input wire logic [1:0] i_high,
  output logic [4:0] o_pin_in
);
  // after the straps are taken the controller keeps toggling its outputs,
  // so a design that samples late sees the strap value by luck only when the straps are 5'h15 or 5'h0A
  logic [4:0] scramble_reg = 5'h15;
  always_ff @(posedge i_clock) begin
    scramble_reg <= ~scramble_reg;
  end
  assign o_pin_in = i_released ? scramble_reg : {i_high, i_code};
endmodule
`default_nettype wire

/* bench/strap_config_select_gpio_tb.sv */
// self-checking bench for strap sampling, configuration select and pin control
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module strap_config_select_gpio_tb;
  localparam int unsigned P_READY = 10;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_clk_en = 1'b1;
  logic released = 1'b0;
  logic [2:0] code = 3'h0;
  logic [1:0] high = 2'h0;
  logic [4:0] pin_in, pin_out, pin_oe, pulldown_en;
  logic [9:0] pin_mode = 10'h000;
  logic [4:0] gpo_value = 5'h00;
  logic [4:0] pulldown_dis = 5'h00;
  logic [14:0] status_sel = 15'h0000;
  logic [7:0] status = 8'h00;
  logic irq_ack = 1'b0;
  logic [6:0] cfg_present = 7'h7F;
  logic cfg_load, factory_default, strap_fault, regs_ready, irq_pending;
  logic [2:0] cfg_index;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  initial begin
    forever #2.5 i_clock = ~i_clock;
  end

  scsg_board board_u (.i_clock(i_clock), .i_released(released), .i_code(code), .i_high(high), .o_pin_in(pin_in));

  scsg_top #(.P_READY_CYCLES(P_READY)) dut_u (
    .i_clock(i_clock), .i_rst(i_rst), .i_clk_en(i_clk_en), .i_pin_in(pin_in), .o_pin_out(pin_out),
    .o_pin_oe(pin_oe), .o_pulldown_en(pulldown_en), .i_pin_mode(pin_mode), .i_gpo_value(gpo_value),
    .i_pulldown_dis(pulldown_dis), .i_status_sel(status_sel), .i_status(status), .i_irq_ack(irq_ack),
    .i_cfg_present(cfg_present), .o_cfg_load(cfg_load), .o_cfg_index(cfg_index),
    .o_factory_default(factory_default), .o_strap_fault(strap_fault), .o_regs_ready(regs_ready),
    .o_irq_pending(irq_pending));

  task automatic end_of_test();
    if (n_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ceiling is over twenty times the expected run length
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      end_of_test();
    end
  end

  // reset for 2 cycles, release, let strap edge 1 and result edge 2 pass
  task automatic strap_reset(input logic [2:0] c, input logic [1:0] h);
    @(posedge i_clock);
    i_rst <= 1'b1;
    released <= 1'b0;
    code <= c;
    high <= h;
    pin_mode <= 10'h000;
    repeat (2) @(posedge i_clock);
    `CHK("pulldown_in_reset", 5'h1F, pulldown_en)
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clock);
    released <= 1'b1;
    @(negedge i_clock);
  endtask

  task automatic t_codes();
    for (int c = 0; c < 8; c++) begin
      strap_reset(3'(c), 2'h0);
      `CHK("cfg_index", 3'(c), cfg_index)
      `CHK("cfg_load", (c != 7), cfg_load)
      `CHK("factory", (c == 7), factory_default)
      `CHK("fault_clear", 1'b0, strap_fault)
      @(negedge i_clock);
      `CHK("load_pulse_end", 1'b0, cfg_load)
    end
  endtask

  task automatic t_empty_and_fault();
    @(posedge i_clock);
    cfg_present <= 7'h7B;
    strap_reset(3'h2, 2'h1);
    `CHK("empty_factory", 1'b1, factory_default)
    `CHK("empty_no_load", 1'b0, cfg_load)
    `CHK("fault_set", 1'b1, strap_fault)
    @(posedge i_clock);
    cfg_present <= 7'h7F;
  endtask

  task automatic t_ready();
    strap_reset(3'h1, 2'h0);
    repeat (P_READY) @(posedge i_clock);
    @(negedge i_clock);
    `CHK("ready_early", 1'b0, regs_ready)
    @(negedge i_clock);
    `CHK("ready_on_time", 1'b1, regs_ready)
  endtask

  task automatic t_pins();
    strap_reset(3'h3, 2'h0);
    @(posedge i_clock);
    pin_mode <= 10'h009;
    gpo_value <= 5'h01;
    status_sel <= 15'h0028;
    status <= 8'h20;
    pulldown_dis <= 5'h15;
    @(posedge i_clock);
    @(negedge i_clock);
    `CHK("pin_out", 2'h3, pin_out[1:0])
    `CHK("pin_oe", 5'h03, pin_oe)
    `CHK("pulldown_en", 5'h0A, pulldown_en)
    @(posedge i_clock);
    status <= 8'h00;
    pulldown_dis <= 5'h00;
  endtask

  task automatic t_irq();
    strap_reset(3'h0, 2'h0);
    `CHK("irq_idle", 1'b0, irq_pending)
    @(posedge i_clock);
    pin_mode <= 10'h003;
    status <= status ^ 8'h01;
    @(posedge i_clock);
    @(negedge i_clock);
    `CHK("irq_set", 1'b1, irq_pending)
    @(negedge i_clock);
    `CHK("irq_pin", 2'h3, {pin_oe[0], pin_out[0]})
    @(posedge i_clock);
    irq_ack <= 1'b1;
    @(posedge i_clock);
    irq_ack <= 1'b0;
    @(negedge i_clock);
    `CHK("irq_cleared", 1'b0, irq_pending)
    @(negedge i_clock);
    `CHK("irq_pin_low", 1'b0, pin_out[0])
    // a change landing on the acknowledge edge must keep the flag set
    @(posedge i_clock);
    status <= status ^ 8'h02;
    irq_ack <= 1'b1;
    @(posedge i_clock);
    irq_ack <= 1'b0;
    @(negedge i_clock);
    `CHK("irq_set_wins", 1'b1, irq_pending)
  endtask

  // clock enable low for four edges: nothing moves, the access delay slips by as much
  task automatic t_hold();
    strap_reset(3'h6, 2'h0);
    @(posedge i_clock);
    i_clk_en <= 1'b0;
    status <= 8'h80;
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
    `CHK("irq_frozen", 1'b0, irq_pending)
    @(posedge i_clock);
    i_clk_en <= 1'b1;
    @(posedge i_clock);
    @(negedge i_clock);
    `CHK("irq_after_hold", 1'b1, irq_pending)
    repeat (8) @(posedge i_clock);
    @(negedge i_clock);
    `CHK("ready_held_back", 1'b0, regs_ready)
    @(negedge i_clock);
    `CHK("ready_after_hold", 1'b1, regs_ready)
  endtask

  initial begin
    t_codes();
    t_empty_and_fault();
    t_ready();
    t_pins();
    t_irq();
    t_hold();
    end_of_test();
  end
endmodule
`default_nettype wire
